// ==== logic/conv_ctrl_pkg.sv ====
// Register map, field positions, reset values and sequence counts of the converter control
package conv_ctrl_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] CFG_OFFSET      = 8'h04;
  localparam logic [7:0] RES_LOW_OFFSET  = 8'h08;
  localparam logic [7:0] RES_HIGH_OFFSET = 8'h0C;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_DELAY_BIT  = 6;
  localparam int CTRL_DONE_BIT   = 5;
  localparam int CTRL_BUSY_BIT   = 4;
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_SRC_MSB    = 2;

  // Configuration register fields
  localparam int CFG_DIV_LSB     = 3;
  localparam int CFG_DIV_MSB     = 7;
  localparam int CFG_JUSTIFY_BIT = 2;
  localparam int CFG_NARROW_BIT  = 1;

  // Values after reset
  localparam logic [4:0] DIV_RESET     = 5'h1F;
  localparam logic       JUSTIFY_RESET = 1'b0;
  localparam logic       NARROW_RESET  = 1'b0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Sequence lengths in conversion-clock ticks
  localparam logic [3:0] DELAY_TICKS  = 4'h3;
  localparam logic [3:0] SETTLE_TICKS = 4'h2;
  localparam logic [3:0] WIDE_BITS    = 4'hA;
  localparam logic [3:0] NARROW_BITS  = 4'h8;
  localparam logic [3:0] WIDE_TICKS   = 4'hD;
  localparam logic [3:0] NARROW_TICKS = 4'hB;

  // Conversion trigger encodings
  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'b000,
    SRC_TIMER0   = 3'b001,
    SRC_TIMER2   = 3'b010,
    SRC_TIMER1   = 3'b011,
    SRC_EXT_PIN  = 3'b100,
    SRC_TIMER3   = 3'b101
  } start_source_e;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_e;

endpackage : conv_ctrl_pkg

// ==== logic/conversion_control.sv ====
// Control logic of the 10-bit successive-approximation converter
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

module conversion_control
  import conv_ctrl_pkg::*;
#(
  parameter int RESULT_BITS = 10
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  // Timer overflow pulses, same clock
  input  wire logic       timer0_ovf_in,
  input  wire logic       timer1_ovf_in,
  input  wire logic       timer2_low_ovf_in,
  input  wire logic       timer2_high_ovf_in,
  input  wire logic       timer2_split_in,
  input  wire logic       timer3_low_ovf_in,
  input  wire logic       timer3_high_ovf_in,
  input  wire logic       timer3_split_in,
  // External start pin, asynchronous
  input  wire logic       external_start_pin_in,
  // Analog front end
  input  wire logic       comparator_in,
  output logic      [9:0] dac_code_out,
  output logic            track_out,
  output logic            shutdown_out,
  // Status
  output logic            busy_out,
  output logic            done_flag_out
);

  if (RESULT_BITS != 10) begin : gen_width_check
    $error("conversion_control supports only a 10-bit result");
  end

  // Register state
  logic                converter_enable_q;
  logic                delayed_track_enable_q;
  logic                conversion_done_flag_q;
  logic          [2:0] start_source_select_q;
  logic          [4:0] sar_clock_divider_q;
  logic                justify_select_q;
  logic                narrow_mode_enable_q;
  logic          [7:0] result_high_byte_q;
  logic          [7:0] result_low_byte_q;
  logic          [7:0] reg_rdata_q;

  // Sequencer state
  conv_state_e         state_q;
  logic          [4:0] div_count_q;
  logic          [3:0] tick_count_q;
  logic                narrow_active_q;
  logic          [9:0] sar_code_q;
  logic          [9:0] sar_code_d;
  logic                track_q;

  // Synchronisers
  logic          [1:0] pin_sync_q;
  logic                pin_last_q;
  logic          [1:0] cmp_sync_q;

  logic                ctrl_write;
  logic                sw_start;
  logic                trigger;
  logic                start;
  logic                sar_tick;
  logic          [3:0] total_ticks;
  logic          [3:0] bit_ticks;
  logic                in_bit_phase;
  logic          [3:0] bit_step;
  logic                finish;
  logic                pin_sync;
  logic                pin_rise;
  logic                enable_next;
  logic                delay_next;
  logic                delay_done;

  assign ctrl_write = reg_write_in && (reg_addr_in == CTRL_OFFSET);
  assign pin_sync   = pin_sync_q[1];
  assign pin_rise   = pin_sync && !pin_last_q;

  // Pin and comparator come from outside the clock domain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_sync_q <= 2'b00;
      pin_last_q <= 1'b0;
      cmp_sync_q <= 2'b00;
    end else begin
      pin_sync_q <= {pin_sync_q[0], external_start_pin_in};
      pin_last_q <= pin_sync;
      cmp_sync_q <= {cmp_sync_q[0], comparator_in};
    end
  end

  // Software start takes the source and enable being written in the same access
  assign sw_start = ctrl_write && reg_wdata_in[CTRL_BUSY_BIT]
                    && reg_wdata_in[CTRL_ENABLE_BIT]
                    && (reg_wdata_in[CTRL_SRC_MSB:CTRL_SRC_LSB] == SRC_SOFTWARE);

  always_comb begin
    unique case (start_source_select_q)
      SRC_SOFTWARE: trigger = 1'b0;
      SRC_TIMER0:   trigger = timer0_ovf_in;
      SRC_TIMER2:   trigger = timer2_split_in ? timer2_low_ovf_in : timer2_high_ovf_in;
      SRC_TIMER1:   trigger = timer1_ovf_in;
      SRC_EXT_PIN:  trigger = pin_rise;
      SRC_TIMER3:   trigger = timer3_split_in ? timer3_low_ovf_in : timer3_high_ovf_in;
      default:      trigger = 1'b0;
    endcase
  end

  // A software start may enable the converter and pick the delay in the same write,
  // so the sequence follows the values being written, not the old ones
  assign enable_next = ctrl_write ? reg_wdata_in[CTRL_ENABLE_BIT] : converter_enable_q;
  assign delay_next  = ctrl_write ? reg_wdata_in[CTRL_DELAY_BIT] : delayed_track_enable_q;

  // Triggers arriving while a conversion runs are dropped, not queued
  assign start = (state_q == ST_IDLE)
                 && ((converter_enable_q && trigger) || sw_start);

  // Conversion clock enable: one pulse every divider+1 system cycles,
  // held at zero in idle and restarted on each accepted start so the sequence is aligned to it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_count_q <= 5'h00;
    end else if (start || state_q == ST_IDLE) begin
      div_count_q <= 5'h00;
    end else if (div_count_q == sar_clock_divider_q) begin
      div_count_q <= 5'h00;
    end else begin
      div_count_q <= div_count_q + 5'h01;
    end
  end

  // The 500 ksps ceiling is met by choosing a divider that keeps the conversion clock in range
  assign sar_tick = (state_q != ST_IDLE) && (div_count_q == sar_clock_divider_q);

  // Settle ticks, one tick per bit, then one tick to store the result
  assign total_ticks  = narrow_active_q ? NARROW_TICKS : WIDE_TICKS;
  assign bit_ticks    = narrow_active_q ? NARROW_BITS : WIDE_BITS;
  assign in_bit_phase = (tick_count_q >= SETTLE_TICKS)
                        && (tick_count_q < SETTLE_TICKS + bit_ticks);
  assign bit_step     = tick_count_q - SETTLE_TICKS;
  assign finish       = (state_q == ST_CONVERT) && sar_tick
                        && (tick_count_q == total_ticks - 4'h1);
  assign delay_done   = (state_q == ST_DELAY) && sar_tick
                        && (tick_count_q == DELAY_TICKS - 4'h1);

  // Sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q         <= ST_IDLE;
      tick_count_q    <= 4'h0;
      narrow_active_q <= NARROW_RESET;
    end else if (!converter_enable_q && !start) begin
      state_q      <= ST_IDLE;
      tick_count_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          tick_count_q    <= 4'h0;
          narrow_active_q <= narrow_mode_enable_q;
          if (start) begin
            state_q <= delay_next ? ST_DELAY : ST_CONVERT;
          end
        end
        ST_DELAY: begin
          if (sar_tick) begin
            if (tick_count_q == DELAY_TICKS - 4'h1) begin
              state_q      <= ST_CONVERT;
              tick_count_q <= 4'h0;
            end else begin
              tick_count_q <= tick_count_q + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (finish) begin
            state_q      <= ST_IDLE;
            tick_count_q <= 4'h0;
          end else if (sar_tick) begin
            tick_count_q <= tick_count_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation: keep the trial bit if the input is at or above
  // the trial code, then try the next lower bit
  always_comb begin
    sar_code_d = sar_code_q;
    if (state_q != ST_CONVERT) begin
      sar_code_d = 10'h200;
    end else if (sar_tick && in_bit_phase) begin
      for (int b = 0; b < 10; b++) begin
        if (b == 9 - int'(bit_step)) begin
          sar_code_d[b] = cmp_sync_q[1];
          if (b > 0 && int'(bit_step) < int'(bit_ticks) - 1) begin
            sar_code_d[b-1] = 1'b1;
          end
        end
      end
    end
  end

  // In narrow mode the two low trial bits are never set, so they stay zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sar_code_q <= 10'h000;
    end else begin
      sar_code_q <= sar_code_d;
    end
  end

  // Tracking: internal sources track whenever enabled and not converting; pin source
  // without delay tracks only while the pin is low
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      track_q <= 1'b0;
    end else if (!converter_enable_q && !start) begin
      track_q <= 1'b0;
    end else if (start) begin
      track_q <= delay_next;
    end else if (state_q == ST_CONVERT || delay_done) begin
      track_q <= 1'b0;
    end else if (state_q == ST_DELAY) begin
      track_q <= 1'b1;
    end else if (start_source_select_q == SRC_EXT_PIN && !delayed_track_enable_q) begin
      track_q <= !pin_sync;
    end else begin
      track_q <= 1'b1;
    end
  end

  // Result bytes are written in the cycle the done flag sets, so they are valid with it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      result_high_byte_q <= BYTE_ZERO;
      result_low_byte_q  <= BYTE_ZERO;
    end else if (finish) begin
      if (narrow_active_q) begin
        result_high_byte_q <= sar_code_q[9:2];
        result_low_byte_q  <= BYTE_ZERO;
      end else if (justify_select_q) begin
        result_high_byte_q <= sar_code_q[9:2];
        result_low_byte_q  <= {sar_code_q[1:0], 6'b00_0000};
      end else begin
        result_high_byte_q <= {6'b00_0000, sar_code_q[9:8]};
        result_low_byte_q  <= sar_code_q[7:0];
      end
    end
  end

  // Control register; the done flag clears on a write of 0, and a finishing
  // conversion in the same cycle wins
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      converter_enable_q     <= 1'b0;
      delayed_track_enable_q <= 1'b0;
      start_source_select_q  <= SRC_SOFTWARE;
      conversion_done_flag_q <= 1'b0;
    end else begin
      if (ctrl_write) begin
        converter_enable_q     <= reg_wdata_in[CTRL_ENABLE_BIT];
        delayed_track_enable_q <= reg_wdata_in[CTRL_DELAY_BIT];
        start_source_select_q  <= reg_wdata_in[CTRL_SRC_MSB:CTRL_SRC_LSB];
      end
      if (finish) begin
        conversion_done_flag_q <= 1'b1;
      end else if (ctrl_write && !reg_wdata_in[CTRL_DONE_BIT]) begin
        conversion_done_flag_q <= 1'b0;
      end
    end
  end

  // Configuration register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sar_clock_divider_q  <= DIV_RESET;
      justify_select_q     <= JUSTIFY_RESET;
      narrow_mode_enable_q <= NARROW_RESET;
    end else if (reg_write_in && reg_addr_in == CFG_OFFSET) begin
      sar_clock_divider_q  <= reg_wdata_in[CFG_DIV_MSB:CFG_DIV_LSB];
      justify_select_q     <= reg_wdata_in[CFG_JUSTIFY_BIT];
      narrow_mode_enable_q <= reg_wdata_in[CFG_NARROW_BIT];
    end
  end

  // Read port: data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_q <= BYTE_ZERO;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        CTRL_OFFSET: begin
          reg_rdata_q <= {converter_enable_q, delayed_track_enable_q, conversion_done_flag_q,
                          (state_q != ST_IDLE), 1'b0, start_source_select_q};
        end
        CFG_OFFSET: begin
          reg_rdata_q <= {sar_clock_divider_q, justify_select_q, narrow_mode_enable_q, 1'b0};
        end
        RES_LOW_OFFSET:  reg_rdata_q <= result_low_byte_q;
        RES_HIGH_OFFSET: reg_rdata_q <= result_high_byte_q;
        default:         reg_rdata_q <= BYTE_ZERO;
      endcase
    end else begin
      reg_rdata_q <= BYTE_ZERO;
    end
  end

  // Status and front-end outputs
  logic busy_q;
  logic shutdown_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy_q     <= 1'b0;
      shutdown_q <= 1'b1;
    end else begin
      busy_q     <= start || (state_q != ST_IDLE && !finish && converter_enable_q);
      shutdown_q <= !enable_next;
    end
  end

  assign reg_rdata_out = reg_rdata_q;
  assign dac_code_out  = sar_code_q;
  assign track_out     = track_q;
  assign shutdown_out  = shutdown_q;
  assign busy_out      = busy_q;
  assign done_flag_out = conversion_done_flag_q;

endmodule : conversion_control

// ==== test/analog_source.sv ====
// Analog input and comparator model facing the trial code
`timescale 1ns/1ps

module analog_source (
  // Clock and trial code
  input  wire logic       clk_in,
  input  wire logic [9:0] dac_code_in,
  // Level under test and answer speed
  input  wire logic [9:0] level_in,
  input  wire logic       slow_in,
  // Decision
  output logic            comparator_out
);
  logic held_q;

  always_ff @(posedge clk_in) begin
    held_q <= level_in >= dac_code_in;
  end

  // Slow answers lag one cycle, the most a divider of 3 tolerates
  assign comparator_out = slow_in ? held_q : (level_in >= dac_code_in);
endmodule : analog_source

// ==== test/conv_ctrl_props.sv ====
// Port assertions for the converter control block
`timescale 1ns/1ps

module conv_ctrl_props
  import conv_ctrl_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       timer0_ovf_in,
  input wire logic       timer1_ovf_in,
  input wire logic       timer2_low_ovf_in,
  input wire logic       timer2_high_ovf_in,
  input wire logic       timer2_split_in,
  input wire logic       timer3_low_ovf_in,
  input wire logic       timer3_high_ovf_in,
  input wire logic       timer3_split_in,
  input wire logic       external_start_pin_in,
  input wire logic [9:0] dac_code_out,
  input wire logic       track_out,
  input wire logic       shutdown_out,
  input wire logic       busy_out,
  input wire logic       done_flag_out
);
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [9:0] cnt_q;
  logic [9:0] exp_len;
  logic       ctrl_wr;
  logic       tmr_hit;

  assign ctrl_wr = reg_write_in && reg_addr_in == CTRL_OFFSET;
  assign exp_len = ((cfg_q[1] ? 10'h00B : 10'h00D) + (ctrl_q[6] ? 10'h003 : 10'h000))
                 * ({5'h00, cfg_q[7:3]} + 10'h001);
  assign tmr_hit = (ctrl_q[2:0] == SRC_TIMER0 && timer0_ovf_in)
                || (ctrl_q[2:0] == SRC_TIMER1 && timer1_ovf_in)
                || (ctrl_q[2:0] == SRC_TIMER2
                    && (timer2_split_in ? timer2_low_ovf_in : timer2_high_ovf_in))
                || (ctrl_q[2:0] == SRC_TIMER3
                    && (timer3_split_in ? timer3_low_ovf_in : timer3_high_ovf_in));

  // Shadow of the settings that decide triggers and conversion length
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= 8'h00;
      cfg_q  <= 8'hF8;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata_in;
    end else if (reg_write_in && reg_addr_in == CFG_OFFSET) begin
      cfg_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || !busy_out) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence sw_go_s;
    ctrl_wr && reg_wdata_in[7] && reg_wdata_in[4] && reg_wdata_in[2:0] == SRC_SOFTWARE
      && !busy_out;
  endsequence

  sequence quiet_s;
    ctrl_q[7] && !busy_out
      && (ctrl_q[2:0] != SRC_EXT_PIN || ctrl_q[6] || !external_start_pin_in);
  endsequence

  shut_on_a: assert property (ctrl_wr && !reg_wdata_in[7] |-> ##[1:2] shutdown_out)
    else $error("shutdown not raised after disable");
  shut_idle_a: assert property (shutdown_out [*2] |-> !busy_out)
    else $error("busy while shut down");
  sw_start_a: assert property (sw_go_s |=> busy_out)
    else $error("software start ignored");
  tmr_start_a: assert property (ctrl_q[7] && !busy_out && tmr_hit |=> busy_out)
    else $error("timer start ignored");
  pin_start_a: assert property (ctrl_q[7] && ctrl_q[2:0] == SRC_EXT_PIN && !busy_out
    && $rose(external_start_pin_in) |-> ##[2:5] busy_out) else $error("pin start ignored");
  start_state_a: assert property ($rose(busy_out)
    |-> dac_code_out == 10'h200 && track_out == ctrl_q[6]) else $error("bad start state");
  idle_track_a: assert property (quiet_s [*4] |-> track_out)
    else $error("not tracking while idle");
  done_set_a: assert property ($fell(busy_out) |-> done_flag_out)
    else $error("done flag not set at end");
  conv_len_a: assert property ($fell(busy_out) |-> cnt_q == exp_len)
    else $error("conversion length wrong");
endmodule : conv_ctrl_props

bind conversion_control conv_ctrl_props u_props (
  .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .timer0_ovf_in(timer0_ovf_in),
  .timer1_ovf_in(timer1_ovf_in), .timer2_low_ovf_in(timer2_low_ovf_in),
  .timer2_high_ovf_in(timer2_high_ovf_in), .timer2_split_in(timer2_split_in),
  .timer3_low_ovf_in(timer3_low_ovf_in), .timer3_high_ovf_in(timer3_high_ovf_in),
  .timer3_split_in(timer3_split_in), .external_start_pin_in(external_start_pin_in),
  .dac_code_out(dac_code_out), .track_out(track_out), .shutdown_out(shutdown_out),
  .busy_out(busy_out), .done_flag_out(done_flag_out)
);

// ==== test/testbench.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps

module testbench;
  import conv_ctrl_pkg::*;
  logic       clk_in   = 1'b0;
  logic       reset_in = 1'b1;
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic [5:0] tmr      = 6'h00;
  logic       pin      = 1'b0;
  logic       slow     = 1'b0;
  logic [9:0] level    = 10'h000;
  logic [7:0] rdata;
  logic [9:0] dac;
  logic       cmp;
  int         fail_count = 0;
  int         compares   = 0;

  always #4 clk_in = ~clk_in;

  conversion_control uut (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .timer0_ovf_in(tmr[0]),
    .timer1_ovf_in(tmr[1]), .timer2_low_ovf_in(tmr[2]), .timer2_high_ovf_in(tmr[3]),
    .timer2_split_in(1'b1), .timer3_low_ovf_in(tmr[4]), .timer3_high_ovf_in(tmr[5]),
    .timer3_split_in(1'b0), .external_start_pin_in(pin), .comparator_in(cmp),
    .dac_code_out(dac), .track_out(), .shutdown_out(), .busy_out(), .done_flag_out()
  );

  analog_source partner (
    .clk_in(clk_in), .dac_code_in(dac), .level_in(level), .slow_in(slow), .comparator_out(cmp)
  );

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask : rd_reg

  task automatic pulse(input int n);
    @(posedge clk_in) tmr <= 6'(1 << n);
    @(posedge clk_in) tmr <= 6'h00;
  endtask : pulse

  // Polls the done flag, reads the result, then rewrites ctrl to clear done
  task automatic conv_check(input logic [15:0] exp, input logic [7:0] ctrl);
    logic [7:0] d = 8'h00;
    logic [7:0] lo;
    int         n = 0;
    while (d[5] !== 1'b1 && n < 300) begin
      rd_reg(CTRL_OFFSET, d);
      n++;
    end
    chk("done_busy", {14'h0000, d[5:4]}, 16'h0002);
    rd_reg(RES_LOW_OFFSET, lo);
    rd_reg(RES_HIGH_OFFSET, d);
    chk("result", {d, lo}, exp);
    wr_reg(CTRL_OFFSET, ctrl);
  endtask : conv_check

  function automatic logic [15:0] fmt(input logic [9:0] c, input int m);
    case (m)
      0: fmt = {6'h00, c};
      1: fmt = {c, 6'h00};
      default: fmt = {c[9:2], 8'h00};
    endcase
  endfunction : fmt

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [9:0] codes [5] = '{10'h3FF, 10'h200, 10'h100, 10'h000, 10'h2A5};
    logic [2:0] srcs [4]  = '{3'h1, 3'h3, 3'h2, 3'h5};
    int         good [4]  = '{0, 1, 2, 5};
    int         bad [4]   = '{1, 0, 3, 4};
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'(4 * i), d);
      chk("reset", {8'h00, d}, i == 1 ? 16'h00F8 : 16'h0000);
    end
    wr_reg(CTRL_OFFSET, 8'h10);
    repeat (4) @(posedge clk_in);
    rd_reg(CTRL_OFFSET, d);
    chk("disabled", {8'h00, d}, 16'h0000);
    // Narrow mode also sets justify to show that it is ignored
    for (int m = 0; m < 3; m++) begin
      wr_reg(CFG_OFFSET, {5'h03, m != 0, m == 2, 1'b0});
      foreach (codes[i]) begin
        @(posedge clk_in) level <= codes[i];
        wr_reg(CTRL_OFFSET, 8'h90);
        rd_reg(CTRL_OFFSET, d);
        chk("busy", {15'h0000, d[4]}, 16'h0001);
        conv_check(fmt(codes[i], m), 8'h80);
      end
    end
    wr_reg(CFG_OFFSET, 8'h18);
    wr_reg(CTRL_OFFSET, 8'hD0);
    conv_check(fmt(level, 0), 8'hC0);
    foreach (srcs[i]) begin
      @(posedge clk_in) slow <= i[0];
      wr_reg(CTRL_OFFSET, {5'h10, srcs[i]});
      pulse(bad[i]);
      repeat (3) @(posedge clk_in);
      rd_reg(CTRL_OFFSET, d);
      chk("no_start", {15'h0000, d[4]}, 16'h0000);
      pulse(good[i]);
      conv_check(fmt(level, 0), {5'h10, srcs[i]});
    end
    // Without the delay the selected start pin both triggers and gates tracking
    wr_reg(CTRL_OFFSET, 8'h84);
    repeat (4) @(posedge clk_in);
    @(posedge clk_in) pin <= 1'b1;
    conv_check(fmt(level, 0), 8'h84);
    @(posedge clk_in) pin <= 1'b0;
    wr_reg(CTRL_OFFSET, 8'h96);
    repeat (3) @(posedge clk_in);
    rd_reg(CTRL_OFFSET, d);
    chk("reserved", {8'h00, d}, 16'h0086);
    print_verdict();
  end
endmodule : testbench
